// ### hdl/csf_pkg.sv
// ==========================================================================
// shared constants and types
// ==========================================================================
package csf_pkg;

  // ========================================================================
  // register map: status index mirrored in every bank, byte address = 4*index
  // ========================================================================
  localparam logic [8:0] STATUS_IDX_B0 = 9'h003; // bank 0 copy
  localparam logic [8:0] STATUS_IDX_B1 = 9'h083; // bank 1 copy
  localparam logic [8:0] STATUS_IDX_B2 = 9'h103; // bank 2 copy
  localparam logic [8:0] STATUS_IDX_B3 = 9'h183; // bank 3 copy
  localparam int ADDR_W = 11; // avalon byte address width
  localparam int IDX_LSB = 2; // word index starts here

  // ========================================================================
  // field positions inside the status byte
  // ========================================================================
  localparam int BIT_IND_PAGE = 7; // indirect page select
  localparam int BIT_DPAGE_HI = 6; // direct page high
  localparam int BIT_DPAGE_LO = 5; // direct page low
  localparam int BIT_WDT_EXP = 4; // watchdog expiry flag (active low)
  localparam int BIT_SLEEP = 3; // sleep entry flag (active low)
  localparam int BIT_ZERO = 2; // zero flag
  localparam int BIT_HCARRY = 1; // half carry flag
  localparam int BIT_CARRY = 0; // carry flag

  // ========================================================================
  // reset values
  // ========================================================================
  localparam logic [7:0] STATUS_RST = 8'h18; // banks 0, both reset flags 1
  localparam logic [31:0] RDATA_RST = 32'h0000_0000; // idle read data
  localparam logic [7:0] NIBBLE_HI_MASK = 8'hF0; // upper nibble mask

  // ========================================================================
  // core operation codes
  // ========================================================================
  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD_W_FILE,
    OP_ADD_LITERAL,
    OP_SUB_LITERAL,
    OP_SUB_W_FILE,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_CLEAR_FILE,
    OP_MOVE_W_TO_FILE,
    OP_BIT_CLEAR,
    OP_BIT_SET,
    OP_NIBBLE_SWAP,
    OP_INCREMENT,
    OP_DECREMENT,
    OP_COMPLEMENT
  } csf_op_type;

endpackage

// ### hdl/csf_alu_flags.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// result and flag calculator for one core operation
// ==========================================================================
module csf_alu_flags
(
  // operation
  input wire csf_pkg::csf_op_type op_in,
  input wire logic [2:0] bit_sel_in,
  // operands
  input wire logic [7:0] w_in,
  input wire logic [7:0] f_in,
  // results
  output logic [7:0] result_out,
  output logic zero_out,
  output logic half_carry_out,
  output logic carry_out,
  output logic affects_zero_out,
  output logic affects_carries_out
);

  logic [8:0] sum; // full adder result with carry
  logic [4:0] low_sum; // low nibble adder for half carry
  logic [7:0] add_a; // first adder operand
  logic [7:0] add_b; // second adder operand, inverted for subtract
  logic add_cin; // adder carry in

  // ========================================================================
  // adder, subtraction as a + ~b + 1 so carries read as no-borrow
  // ========================================================================
  always_comb
  begin
    add_a = f_in;
    add_b = w_in;
    add_cin = 1'b0;
    if (op_in == csf_pkg::OP_SUB_LITERAL || op_in == csf_pkg::OP_SUB_W_FILE)
    begin
      add_b = ~w_in;
      add_cin = 1'b1;
    end
    sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
    low_sum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  end

  // ========================================================================
  // result and flag selection per operation
  // ========================================================================
  always_comb
  begin
    result_out = f_in;
    affects_zero_out = 1'b0;
    affects_carries_out = 1'b0;
    case (op_in)
      csf_pkg::OP_ADD_W_FILE, csf_pkg::OP_ADD_LITERAL,
      csf_pkg::OP_SUB_LITERAL, csf_pkg::OP_SUB_W_FILE:
      begin
        result_out = sum[7:0];
        affects_zero_out = 1'b1;
        affects_carries_out = 1'b1;
      end
      csf_pkg::OP_AND:
      begin
        result_out = w_in & f_in;
        affects_zero_out = 1'b1;
      end
      csf_pkg::OP_OR:
      begin
        result_out = w_in | f_in;
        affects_zero_out = 1'b1;
      end
      csf_pkg::OP_XOR:
      begin
        result_out = w_in ^ f_in;
        affects_zero_out = 1'b1;
      end
      csf_pkg::OP_CLEAR_FILE:
      begin
        result_out = 8'h00;
        affects_zero_out = 1'b1;
      end
      csf_pkg::OP_INCREMENT:
      begin
        result_out = f_in + 8'h01;
        affects_zero_out = 1'b1;
      end
      csf_pkg::OP_DECREMENT:
      begin
        result_out = f_in - 8'h01;
        affects_zero_out = 1'b1;
      end
      csf_pkg::OP_COMPLEMENT:
      begin
        result_out = ~f_in;
        affects_zero_out = 1'b1;
      end
      // flag-neutral operations
      csf_pkg::OP_MOVE_W_TO_FILE: result_out = w_in;
      csf_pkg::OP_BIT_CLEAR: result_out = f_in & ~(8'h01 << bit_sel_in);
      csf_pkg::OP_BIT_SET: result_out = f_in | (8'h01 << bit_sel_in);
      csf_pkg::OP_NIBBLE_SWAP: result_out = {f_in[3:0], f_in[7:4]};
      default: result_out = f_in;
    endcase
    zero_out = (result_out == 8'h00);
    half_carry_out = low_sum[4];
    carry_out = sum[8];
  end

endmodule
`default_nettype wire

// ### hdl/csf_core_status.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module csf_core_status
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // core instruction port
  input wire logic exec_valid_in,
  input wire csf_pkg::csf_op_type op_in,
  input wire logic [8:0] file_addr_in,
  input wire logic dest_file_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] w_in,
  input wire logic [7:0] f_in,
  // power management events
  input wire logic wdt_timeout_in,
  input wire logic sleep_in,
  // avalon-mm slave
  input wire logic [csf_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // results and bank selects
  output logic [7:0] result_out,
  output logic result_valid_out,
  output logic [7:0] status_out,
  output logic indirect_page_select_out,
  output logic [1:0] direct_page_out
);

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    logic [7:0] status; // the status byte
    logic waitreq; // bus waitrequest
    logic [31:0] rdata; // bus read data
    logic [7:0] result; // last core result
    logic result_valid; // result strobe
  } csf_state_type;

  csf_state_type state_reg; // registered state
  csf_state_type state_next; // next state

  logic [7:0] alu_result; // calculator result
  logic alu_zero; // calculator zero flag
  logic alu_hcarry; // calculator half carry
  logic alu_carry; // calculator carry
  logic alu_aff_zero; // op updates zero flag
  logic alu_aff_carries; // op updates both carries
  logic [7:0] operand_f; // file operand, status when addressed
  logic core_hits_status; // core addresses the status register
  logic bus_req; // bus request pending and not yet answered
  logic bus_hits_status; // bus addresses the status register

  // ========================================================================
  // status address decode, every bank copy maps to one register
  // ========================================================================
  function automatic logic is_status_idx(input logic [8:0] idx);
    is_status_idx = (idx == csf_pkg::STATUS_IDX_B0) || (idx == csf_pkg::STATUS_IDX_B1) ||
                    (idx == csf_pkg::STATUS_IDX_B2) || (idx == csf_pkg::STATUS_IDX_B3);
  endfunction

  assign core_hits_status = is_status_idx(file_addr_in);
  assign bus_hits_status = is_status_idx(avs_address_in[csf_pkg::ADDR_W-1:csf_pkg::IDX_LSB]);
  assign operand_f = core_hits_status ? state_reg.status : f_in;
  assign bus_req = (avs_read_in || avs_write_in) && state_reg.waitreq;

  // ========================================================================
  // result and flag calculator
  // ========================================================================
  csf_alu_flags u_alu
  (
    .op_in(op_in),
    .bit_sel_in(bit_sel_in),
    .w_in(w_in),
    .f_in(operand_f),
    .result_out(alu_result),
    .zero_out(alu_zero),
    .half_carry_out(alu_hcarry),
    .carry_out(alu_carry),
    .affects_zero_out(alu_aff_zero),
    .affects_carries_out(alu_aff_carries)
  );

  // ========================================================================
  // next state
  // ========================================================================
  always_comb
  begin
    state_next = state_reg;
    state_next.result_valid = 1'b0;
    state_next.waitreq = 1'b1;
    // core instruction
    if (exec_valid_in && op_in != csf_pkg::OP_NOP)
    begin
      state_next.result = alu_result;
      state_next.result_valid = 1'b1;
      if (dest_file_in && core_hits_status)
      begin
        // upper bits take the data, reset-cause bits are kept
        state_next.status[7:5] = alu_result[7:5];
        if (!(alu_aff_zero || alu_aff_carries))
        begin
          state_next.status[2:0] = alu_result[2:0];
        end
      end
      // flag updates override any data write to those bits
      if (alu_aff_zero)
      begin
        state_next.status[csf_pkg::BIT_ZERO] = alu_zero;
      end
      if (alu_aff_carries)
      begin
        state_next.status[csf_pkg::BIT_HCARRY] = alu_hcarry;
        state_next.status[csf_pkg::BIT_CARRY] = alu_carry;
      end
    end
    else if (bus_req)
    begin
      // software access, held off while the core executes
      state_next.waitreq = 1'b0;
      state_next.rdata = csf_pkg::RDATA_RST;
      if (bus_hits_status)
      begin
        if (avs_read_in)
        begin
          state_next.rdata = {24'h000000, state_reg.status};
        end
        else if (avs_byteenable_in[0])
        begin
          // software write acts as a plain move, reset-cause bits kept
          state_next.status[7:5] = avs_writedata_in[7:5];
          state_next.status[2:0] = avs_writedata_in[2:0];
        end
      end
    end
    // power management, the only writer of the reset-cause flags
    if (sleep_in)
    begin
      state_next.status[csf_pkg::BIT_WDT_EXP] = 1'b1;
      state_next.status[csf_pkg::BIT_SLEEP] = 1'b0;
    end
    if (wdt_timeout_in)
    begin
      state_next.status[csf_pkg::BIT_WDT_EXP] = 1'b0;
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg.status <= csf_pkg::STATUS_RST;
      state_reg.waitreq <= 1'b1;
      state_reg.rdata <= csf_pkg::RDATA_RST;
      state_reg.result <= 8'h00;
      state_reg.result_valid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // outputs, all straight from the state register
  // ========================================================================
  assign avs_readdata_out = state_reg.rdata;
  assign avs_waitrequest_out = state_reg.waitreq;
  assign result_out = state_reg.result;
  assign result_valid_out = state_reg.result_valid;
  assign status_out = state_reg.status;
  assign indirect_page_select_out = state_reg.status[csf_pkg::BIT_IND_PAGE];
  assign direct_page_out = state_reg.status[csf_pkg::BIT_DPAGE_HI:csf_pkg::BIT_DPAGE_LO];

  // ========================================================================
  // assertions
  // ========================================================================
  logic core_op; // a real instruction this cycle
  assign core_op = exec_valid_in && op_in != csf_pkg::OP_NOP;

  // reset-cause bits move only with power events
  a_reset_flags_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !sleep_in && !wdt_timeout_in |=> $stable(status_out[4:3]))
    else $error("reset-cause bits changed without a power event");

  // watchdog timeout clears the expiry flag
  a_wdt_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wdt_timeout_in |=> !status_out[csf_pkg::BIT_WDT_EXP])
    else $error("watchdog flag not cleared by timeout");

  // sleep sets expiry flag and clears sleep flag
  a_sleep_entry: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sleep_in && !wdt_timeout_in |=> status_out[4:3] == 2'b10)
    else $error("sleep entry pattern wrong");

  // clear-file on status gives 000u u1uu
  a_clear_pattern: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && op_in == csf_pkg::OP_CLEAR_FILE && dest_file_in && core_hits_status
    |=> status_out[7:5] == 3'b000 && status_out[2] && status_out[1:0] == $past(status_out[1:0]))
    else $error("clear-file pattern on status wrong");

  // flag-neutral ops keep flags when aimed elsewhere
  a_neutral_flags: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && !core_hits_status && (op_in == csf_pkg::OP_BIT_SET || op_in == csf_pkg::OP_BIT_CLEAR ||
    op_in == csf_pkg::OP_NIBBLE_SWAP || op_in == csf_pkg::OP_MOVE_W_TO_FILE)
    |=> $stable(status_out[2:0]))
    else $error("flag-neutral op changed flags");

  // arithmetic to status stores alu flags, not data
  a_flag_mask: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && alu_aff_carries && dest_file_in && core_hits_status
    |=> status_out[2:0] == {$past(alu_zero), $past(alu_hcarry), $past(alu_carry)})
    else $error("arithmetic data write reached the flags");

  // equal subtract means no borrow and zero
  a_sub_no_borrow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && (op_in == csf_pkg::OP_SUB_W_FILE || op_in == csf_pkg::OP_SUB_LITERAL) &&
    !core_hits_status && w_in == f_in
    |=> status_out[2:0] == 3'b111)
    else $error("equal subtract flags wrong");

  // low nibble overflow sets half carry
  a_half_carry: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && op_in == csf_pkg::OP_ADD_W_FILE && !core_hits_status &&
    ({1'b0, w_in[3:0]} + {1'b0, f_in[3:0]}) > 5'h0F |=> status_out[1])
    else $error("half carry missing");

  // msb overflow sets carry
  a_carry_out: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && (op_in == csf_pkg::OP_ADD_W_FILE || op_in == csf_pkg::OP_ADD_LITERAL) &&
    !core_hits_status && ({1'b0, w_in} + {1'b0, f_in}) > 9'h0FF |=> status_out[0])
    else $error("carry missing");

  // zero result sets zero flag
  a_zero_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && (op_in == csf_pkg::OP_XOR || op_in == csf_pkg::OP_SUB_LITERAL) &&
    !core_hits_status && w_in == f_in |=> status_out[2])
    else $error("zero flag missing");

  // bank selects take the bits of a software status write
  a_bank_outputs: assert property (@(posedge clk_in) disable iff (!rstn_in)
    bus_req && !core_op && avs_write_in && bus_hits_status && avs_byteenable_in[0]
    |=> {indirect_page_select_out, direct_page_out} == $past(avs_writedata_in[7:5]))
    else $error("bank selects not taken from a status write");

  // mirrored status read returns the status byte
  a_mirror_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    bus_req && !core_op && avs_read_in && bus_hits_status
    |=> !avs_waitrequest_out && avs_readdata_out[7:0] == $past(status_out))
    else $error("mirrored status read wrong");

  // bus request answered once the core is idle
  a_bus_answer: assert property (@(posedge clk_in) disable iff (!rstn_in)
    bus_req && !core_op |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing wrong");

  c_clear_status: cover property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && op_in == csf_pkg::OP_CLEAR_FILE && core_hits_status);
  c_sub_borrow: cover property (@(posedge clk_in) disable iff (!rstn_in)
    core_op && op_in == csf_pkg::OP_SUB_LITERAL ##1 !status_out[0]);
  c_bank3_read: cover property (@(posedge clk_in) disable iff (!rstn_in)
    bus_req && avs_read_in && avs_address_in[10:2] == csf_pkg::STATUS_IDX_B3);
  c_wdt_event: cover property (@(posedge clk_in) disable iff (!rstn_in) wdt_timeout_in);

endmodule
`default_nettype wire

// ### verification/tb_core_status_flag_register.sv
`timescale 1ns/1ps
`default_nettype none
module tb_core_status_flag_register;
  // ==========================================================================
  // clock, reset and stimulus signals
  // ==========================================================================
  logic clk_in = 1'b0; // 25 mhz core clock
  logic rstn_in = 1'b0; // async reset, active low
  logic exec_valid_in = 1'b0; // core executes this cycle
  csf_pkg::csf_op_type op_in = csf_pkg::OP_NOP; // operation code
  logic [8:0] file_addr_in = 9'h020; // file operand address
  logic dest_file_in = 1'b0; // result goes to file
  logic [2:0] bit_sel_in = 3'h0; // bit number for bit ops
  logic [7:0] w_in = 8'h00; // w operand
  logic [7:0] f_in = 8'h00; // file operand or literal
  logic wdt_timeout_in = 1'b0; // watchdog time-out event
  logic sleep_in = 1'b0; // sleep entry event
  logic [10:0] avs_address_in = 11'h000; // bus byte address
  logic avs_read_in = 1'b0; // bus read strobe
  logic avs_write_in = 1'b0; // bus write strobe
  logic [31:0] avs_writedata_in = 32'h0000_0000; // bus write data
  logic [3:0] avs_byteenable_in = 4'hF; // bus byte lanes
  logic [31:0] avs_readdata_out; // bus read data
  logic avs_waitrequest_out; // bus answer, low one cycle
  logic [7:0] result_out; // result of last op
  logic result_valid_out; // result strobe
  logic [7:0] status_out; // status byte
  logic indirect_page_select_out; // indirect bank select
  logic [1:0] direct_page_out; // direct bank select
  // ==========================================================================
  // scoreboard state
  // ==========================================================================
  logic [15:0] core_q[$]; // expected result and status per op
  logic [31:0] rd_q[$]; // expected read data per read
  logic [15:0] core_e; // oldest core note
  logic [31:0] rd_e; // oldest read note
  logic [7:0] exp_st; // model of the status byte
  int failures = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  int cyc = 0; // cycles run, for the hang guard
  csf_pkg::csf_op_type op_tmp; // random mix operation
  logic [8:0] a_tmp; // random mix address
  // clock generator
  always #20 clk_in = ~clk_in;
  // design under test
  csf_core_status u_csf_core_status
  (
    .clk_in(clk_in), .rstn_in(rstn_in), .exec_valid_in(exec_valid_in), .op_in(op_in),
    .file_addr_in(file_addr_in), .dest_file_in(dest_file_in), .bit_sel_in(bit_sel_in),
    .w_in(w_in), .f_in(f_in), .wdt_timeout_in(wdt_timeout_in), .sleep_in(sleep_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .result_out(result_out), .result_valid_out(result_valid_out), .status_out(status_out),
    .indirect_page_select_out(indirect_page_select_out), .direct_page_out(direct_page_out)
  );
  // ==========================================================================
  // helpers
  // ==========================================================================
  // final verdict and end of run
  task automatic test_done();
    check("pending", 32'(core_q.size() + rd_q.size()), 32'h0000_0000);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare and report one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask
  // true for any mirror of the status register
  function automatic logic is_st(input logic [8:0] idx);
    return idx inside {csf_pkg::STATUS_IDX_B0, csf_pkg::STATUS_IDX_B1, csf_pkg::STATUS_IDX_B2, csf_pkg::STATUS_IDX_B3};
  endfunction
  // reference alu: {aff_z, aff_carries, z, dc, c, result}
  function automatic logic [12:0] alu(input csf_pkg::csf_op_type o, input logic [2:0] b,
                                      input logic [7:0] w, input logic [7:0] f);
    logic [8:0] s;
    logic [1:0] aff;
    logic dc;
    s = 9'h000;
    aff = 2'b10;
    dc = 1'b0;
    case (o)
      csf_pkg::OP_ADD_W_FILE, csf_pkg::OP_ADD_LITERAL:
      begin
        s = {1'b0, f} + {1'b0, w};
        dc = ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0F;
        aff = 2'b11;
      end
      csf_pkg::OP_SUB_LITERAL, csf_pkg::OP_SUB_W_FILE:
      begin
        s = {1'b0, f} + {1'b0, ~w} + 9'h001;
        dc = f[3:0] >= w[3:0];
        aff = 2'b11;
      end
      csf_pkg::OP_AND: s = {1'b0, f & w};
      csf_pkg::OP_OR: s = {1'b0, f | w};
      csf_pkg::OP_XOR: s = {1'b0, f ^ w};
      csf_pkg::OP_CLEAR_FILE: s = 9'h000;
      csf_pkg::OP_INCREMENT: s = {1'b0, f + 8'h01};
      csf_pkg::OP_DECREMENT: s = {1'b0, f - 8'h01};
      csf_pkg::OP_COMPLEMENT: s = {1'b0, ~f};
      // these leave every flag alone
      default:
      begin
        aff = 2'b00;
        if (o == csf_pkg::OP_MOVE_W_TO_FILE) s = {1'b0, w};
        else if (o == csf_pkg::OP_BIT_CLEAR) s = {1'b0, f & ~(8'h01 << b)};
        else if (o == csf_pkg::OP_BIT_SET) s = {1'b0, f | (8'h01 << b)};
        else s = {1'b0, f[3:0], f[7:4]};
      end
    endcase
    return {aff, s[7:0] == 8'h00, dc, s[8], s[7:0]};
  endfunction
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [10:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address_in <= a;
    avs_writedata_in <= {24'($urandom), d};
    avs_byteenable_in <= be;
    if (wr) avs_write_in <= 1'b1;
    else avs_read_in <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // bus write, bits 4:3 never taken
  task automatic bus_write(input logic [10:0] a, input logic [7:0] d, input logic [3:0] be);
    if (is_st(a[10:2]) && be[0]) exp_st = {d[7:5], exp_st[4:3], d[2:0]};
    bus_xfer(1'b1, a, d, be);
  endtask
  // bus read, unmapped reads return zero
  task automatic bus_read(input logic [10:0] a);
    rd_q.push_back(is_st(a[10:2]) ? {24'h000000, exp_st} : 32'h0000_0000);
    bus_xfer(1'b0, a, 8'($urandom), 4'hF);
  endtask
  // one core instruction with its expected outcome
  task automatic core_op(input csf_pkg::csf_op_type o, input logic [8:0] a, input logic dst,
                         input logic [2:0] b, input logic [7:0] w, input logic [7:0] f);
    logic [12:0] r;
    logic [7:0] st;
    r = alu(o, b, w, is_st(a) ? exp_st : f);
    st = exp_st;
    if (dst && is_st(a))
    begin
      st[7:5] = r[7:5];
      if (!r[12]) st[2:0] = r[2:0];
    end
    if (r[12]) st[2] = r[10];
    if (r[11]) st[1:0] = r[9:8];
    core_q.push_back({r[7:0], st});
    exp_st = st;
    exec_valid_in <= 1'b1;
    op_in <= o;
    file_addr_in <= a;
    dest_file_in <= dst;
    bit_sel_in <= b;
    w_in <= w;
    f_in <= f;
    @(posedge clk_in);
    exec_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // power events for one cycle
  task automatic pwr(input logic wdt, input logic slp);
    wdt_timeout_in <= wdt;
    sleep_in <= slp;
    if (slp) exp_st[4:3] = 2'b10;
    if (wdt) exp_st[4] = 1'b0;
    @(posedge clk_in);
    wdt_timeout_in <= 1'b0;
    sleep_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // ==========================================================================
  // output monitor and hang guard
  // ==========================================================================
  always @(posedge clk_in)
  begin
    cyc++;
    if (rstn_in && result_valid_out === 1'b1)
    begin
      core_e = (core_q.size() > 0) ? core_q.pop_front() : 16'hXXXX;
      check("result", {24'h000000, result_out}, {24'h000000, core_e[15:8]});
      check("status", {24'h000000, status_out}, {24'h000000, core_e[7:0]});
      check("banks", {29'h0, indirect_page_select_out, direct_page_out}, {29'h0, core_e[7:5]});
    end
    if (rstn_in && avs_read_in && avs_waitrequest_out === 1'b0)
    begin
      rd_e = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hXXXX_XXXX;
      check("readdata", avs_readdata_out, rd_e);
    end
    if (cyc >= 20000)
    begin
      failures++;
      test_done();
    end
  end
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(52302));
    exp_st = 8'h18;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    // reset value through every mirror, then an unmapped place
    bus_read({csf_pkg::STATUS_IDX_B0, 2'b00});
    bus_read({csf_pkg::STATUS_IDX_B1, 2'b00});
    bus_read({csf_pkg::STATUS_IDX_B2, 2'b00});
    bus_read({csf_pkg::STATUS_IDX_B3, 2'b00});
    bus_read(11'h010);
    // reset-cause bits refuse bus writes; masked lane and unmapped writes ignored
    bus_write({csf_pkg::STATUS_IDX_B1, 2'b00}, 8'h00, 4'hF);
    bus_read({csf_pkg::STATUS_IDX_B0, 2'b00});
    bus_write({csf_pkg::STATUS_IDX_B2, 2'b00}, 8'hFF, 4'hE);
    bus_write(11'h010, 8'hFF, 4'hF);
    bus_read({csf_pkg::STATUS_IDX_B3, 2'b00});
    // every bank select pattern
    for (int k = 0; k < 8; k++)
    begin
      bus_write({csf_pkg::STATUS_IDX_B0, 2'b00}, {3'(k), 5'h00}, 4'hF);
      core_op(csf_pkg::OP_MOVE_W_TO_FILE, 9'h020, 1'b1, 3'h0, 8'($urandom), 8'h00);
    end
    // arithmetic corners
    core_op(csf_pkg::OP_ADD_W_FILE, 9'h020, 1'b1, 3'h0, 8'h0F, 8'h01);
    core_op(csf_pkg::OP_SUB_W_FILE, 9'h020, 1'b1, 3'h0, 8'h01, 8'h10);
    core_op(csf_pkg::OP_SUB_LITERAL, 9'h020, 1'b0, 3'h0, 8'h05, 8'h05);
    core_op(csf_pkg::OP_ADD_LITERAL, 9'h020, 1'b0, 3'h0, 8'h80, 8'h80);
    // instructions aimed at the status register
    bus_write({csf_pkg::STATUS_IDX_B0, 2'b00}, 8'hE2, 4'hF);
    core_op(csf_pkg::OP_CLEAR_FILE, csf_pkg::STATUS_IDX_B2, 1'b1, 3'h0, 8'h00, 8'h00);
    core_op(csf_pkg::OP_BIT_SET, csf_pkg::STATUS_IDX_B1, 1'b1, 3'h6, 8'h00, 8'h00);
    core_op(csf_pkg::OP_BIT_CLEAR, csf_pkg::STATUS_IDX_B3, 1'b1, 3'h2, 8'h00, 8'h00);
    core_op(csf_pkg::OP_NIBBLE_SWAP, csf_pkg::STATUS_IDX_B0, 1'b1, 3'h0, 8'h00, 8'h00);
    core_op(csf_pkg::OP_ADD_W_FILE, csf_pkg::STATUS_IDX_B3, 1'b1, 3'h0, 8'hFF, 8'h00);
    // random instruction mix over plain and status addresses
    repeat (60)
    begin
      op_tmp = csf_pkg::csf_op_type'(4'($urandom_range(15, 1)));
      a_tmp = ($urandom_range(1, 0) == 1) ? 9'h020 : {2'($urandom), 7'h03};
      if (op_tmp inside {csf_pkg::OP_ADD_LITERAL, csf_pkg::OP_SUB_LITERAL}) a_tmp = 9'h020;
      core_op(op_tmp, a_tmp, 1'($urandom), 3'($urandom), 8'($urandom), 8'($urandom));
    end
    // reset-cause flags from power events
    pwr(1'b0, 1'b1);
    bus_read({csf_pkg::STATUS_IDX_B1, 2'b00});
    pwr(1'b1, 1'b0);
    bus_read({csf_pkg::STATUS_IDX_B2, 2'b00});
    pwr(1'b1, 1'b1);
    bus_read({csf_pkg::STATUS_IDX_B0, 2'b00});
    // second reset in mid-run
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    exp_st = 8'h18;
    @(posedge clk_in);
    bus_read({csf_pkg::STATUS_IDX_B3, 2'b00});
    test_done();
  end
endmodule
`default_nettype wire
